/* File: shared/cld_pkg.sv */
// shared constants and carriers for the character display instruction decoder
package cld_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned OSC_HZ = 540_000;
  // documented times in nanoseconds at the oscillator rate
  localparam longint unsigned T_LONG_NS = 760_000;
  localparam longint unsigned T_SHORT_NS = 18_500;
  localparam longint unsigned T_BLINK_NS = 185_000_000;
  localparam longint unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  // least times round up
  localparam int unsigned LONG_CYC = int'((T_LONG_NS + CLK_NS - 1) / CLK_NS);
  localparam int unsigned SHORT_CYC = int'((T_SHORT_NS + CLK_NS - 1) / CLK_NS);
  localparam int unsigned BLINK_CYC = int'(T_BLINK_NS / CLK_NS);
  localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
  // fill code, address map and memory depths
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [6:0] ADDR_ZERO = 7'h00;
  localparam logic [6:0] LINE1_LAST = 7'h27;
  localparam logic [6:0] LINE2_FIRST = 7'h40;
  localparam logic [6:0] LINE2_LAST = 7'h67;
  localparam logic [6:0] ONE_LINE_LAST = 7'h4F;
  localparam int unsigned DISP_DEPTH = 128;
  localparam int unsigned PAT_DEPTH = 64;
  // bus word layout
  localparam int unsigned BUSY_BIT = 7;

  typedef enum logic [1:0] {
    CLD_IDLE = 2'b00,
    CLD_EXEC = 2'b01,
    CLD_FILL = 2'b11
  } cld_state_t;

  typedef struct packed {
    logic entry_inc;
    logic entry_shift;
    logic disp_on;
    logic cursor_on;
    logic blink_on;
    logic bus_width_sel;
    logic two_line;
    logic font_tall;
  } cld_mode_t;
endpackage

/* File: core/cld_ram.sv */
// display and pattern memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module cld_ram #(
  parameter int unsigned DEPTH = 128,
  parameter int unsigned AW = 7
) (
  // clock
  input wire logic sys_clk,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read port
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

/* File: core/cld_decoder.sv */
// instruction decoder and execution control for a character display
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - clear fills display RAM with space, zeroes counter, homes cursor, sets increment
// - home zeroes counter and shift offset, display RAM untouched
// - clear and home busy 0.76 ms, others 18.5 us, status read none
// - entry mode stores direction and shift; data accesses step counter
// - pattern RAM accesses step counter the same way
// - shift bit set: display RAM writes shift display by direction
// - display control stores display, cursor, blink enables; off keeps RAM
// - cursor off leaves entry direction unchanged
// - blink toggles cursor cell every 185 ms from counted cycles
// - shift instruction moves cursor or display by select and direction
// - display shift leaves address counter unchanged
// - two-line cursor past line one end goes to line two start
// - display shift moves all lines together
// - function set stores bus width, line count, font
// - pattern address instruction loads six bits, selects pattern RAM
// - display address instruction loads seven bits, selects display RAM
// - status read returns busy on bit 7, counter on bits 6..0
// - data write stores to chosen RAM, data read returns from it
// - in 4-bit mode bytes cross upper lines, high nibble first
module cld_decoder #(
  parameter int unsigned LONG_CYCLES = cld_pkg::LONG_CYC,
  parameter int unsigned BLINK_CYCLES = cld_pkg::BLINK_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // avalon-mm slave: address 0 instruction/status, 1 data
  input wire logic [0:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // state seen by the panel driver
  output cld_pkg::cld_mode_t mode,
  output logic [6:0] shift_offset,
  output logic [6:0] addr_counter,
  output logic busy_flag,
  output logic blink_phase
);
  localparam int unsigned SHORT_CYCLES = cld_pkg::SHORT_CYC;

  typedef struct packed {
    cld_pkg::cld_state_t st;
    cld_pkg::cld_mode_t md;
    logic [6:0] ac;
    logic [6:0] offs;
    logic pat_sel;
    logic [19:0] busy_cnt;
    logic [23:0] blink_cnt;
    logic blink;
    logic [6:0] fill_addr;
    logic lo_nibble;
    logic [3:0] hi_nib;
    logic rd_pend;
    logic [31:0] rdata;
    logic ack;
  } cld_regs_t;

  cld_regs_t r;
  cld_regs_t next_r;
  logic [7:0] disp_rd;
  logic [7:0] pat_rd;
  logic disp_we;
  logic pat_we;
  logic [6:0] disp_wa;
  logic [7:0] disp_wd;
  logic req;
  logic [7:0] wbyte;
  logic full_byte;
  logic [7:0] cmd;

  // step the counter one place, wrapping over the line boundaries
  function automatic logic [6:0] cld_step(input logic [6:0] a,
      input logic up, input logic two, input logic pat);
    logic [6:0] n;
    n = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
    if (pat) begin
      n = {1'b0, n[5:0]};
    end else if (two) begin
      if (up && a == cld_pkg::LINE1_LAST) begin
        n = cld_pkg::LINE2_FIRST;
      end else if (up && a == cld_pkg::LINE2_LAST) begin
        n = cld_pkg::ADDR_ZERO;
      end else if (!up && a == cld_pkg::LINE2_FIRST) begin
        n = cld_pkg::LINE1_LAST;
      end else if (!up && a == cld_pkg::ADDR_ZERO) begin
        n = cld_pkg::LINE2_LAST;
      end
    end else if (up && a == cld_pkg::ONE_LINE_LAST) begin
      n = cld_pkg::ADDR_ZERO;
    end else if (!up && a == cld_pkg::ADDR_ZERO) begin
      n = cld_pkg::ONE_LINE_LAST;
    end
    return n;
  endfunction

  // one offset for the whole panel keeps every line shifting together
  function automatic logic [6:0] cld_shift(input logic [6:0] o,
      input logic left);
    return left ? 7'(o + 7'h01) : 7'(o - 7'h01);
  endfunction

  cld_ram #(.DEPTH(cld_pkg::DISP_DEPTH), .AW(7)) u_disp (
    .sys_clk(sys_clk),
    .wr_en(disp_we),
    .wr_addr(disp_wa),
    .wr_data(disp_wd),
    .rd_addr(r.ac),
    .rd_data(disp_rd)
  );

  cld_ram #(.DEPTH(cld_pkg::PAT_DEPTH), .AW(6)) u_pat (
    .sys_clk(sys_clk),
    .wr_en(pat_we),
    .wr_addr(r.ac[5:0]),
    .wr_data(wbyte),
    .rd_addr(r.ac[5:0]),
    .rd_data(pat_rd)
  );

  always_comb begin
    next_r = r;
    next_r.ack = 1'b0;
    disp_we = 1'b0;
    pat_we = 1'b0;
    disp_wa = r.ac;
    disp_wd = avs_writedata[7:0];
    req = (avs_read || avs_write) && !r.ack;
    // 4-bit mode takes bits 7..4 of each transfer, high nibble first
    wbyte = r.md.bus_width_sel ? avs_writedata[7:0]
                               : {r.hi_nib, avs_writedata[7:4]};
    full_byte = r.md.bus_width_sel || r.lo_nibble;
    cmd = wbyte;

    // blink timebase runs free
    if (r.blink_cnt >= 24'(BLINK_CYCLES - 1)) begin
      next_r.blink_cnt = '0;
      next_r.blink = ~r.blink;
    end else begin
      next_r.blink_cnt = 24'(r.blink_cnt + 24'h1);
    end

    unique case (r.st)
      cld_pkg::CLD_IDLE: begin
      end
      cld_pkg::CLD_EXEC: begin
        if (r.busy_cnt <= 20'h1) begin
          next_r.st = cld_pkg::CLD_IDLE;
          next_r.busy_cnt = '0;
        end else begin
          next_r.busy_cnt = 20'(r.busy_cnt - 20'h1);
        end
      end
      cld_pkg::CLD_FILL: begin
        disp_we = 1'b1;
        disp_wa = r.fill_addr;
        disp_wd = cld_pkg::SPACE_CODE;
        next_r.fill_addr = 7'(r.fill_addr + 7'h01);
        next_r.busy_cnt = 20'(r.busy_cnt - 20'h1);
        if (r.fill_addr == 7'h7F) begin
          next_r.st = cld_pkg::CLD_EXEC;
        end
      end
      default: begin
        next_r.st = cld_pkg::CLD_IDLE;
      end
    endcase

    // reads wait one cycle for registered RAM data
    if (r.rd_pend) begin
      next_r.rd_pend = 1'b0;
      next_r.ack = 1'b1;
      next_r.rdata = {24'h0, r.pat_sel ? pat_rd : disp_rd};
      if (!r.md.bus_width_sel) begin
        next_r.rdata = {24'h0, r.lo_nibble ? next_r.rdata[3:0]
                                           : next_r.rdata[7:4], 4'h0};
        next_r.lo_nibble = ~r.lo_nibble;
      end
      if (r.md.bus_width_sel || r.lo_nibble) begin
        next_r.ac = cld_step(r.ac, r.md.entry_inc, r.md.two_line,
                             r.pat_sel);
        next_r.st = cld_pkg::CLD_EXEC;
        next_r.busy_cnt = 20'(SHORT_CYCLES);
      end
    end else if (req && avs_address == 1'b0 && avs_read) begin
      // status read costs no time and is answered even while busy
      next_r.ack = 1'b1;
      next_r.rdata = {24'h0, r.st != cld_pkg::CLD_IDLE, r.ac};
      if (!r.md.bus_width_sel) begin
        next_r.rdata = {24'h0, r.lo_nibble ? next_r.rdata[3:0]
                                           : next_r.rdata[7:4], 4'h0};
        next_r.lo_nibble = ~r.lo_nibble;
      end
    end else if (req && r.st != cld_pkg::CLD_IDLE) begin
      // host must poll busy first; while busy the request simply waits
    end else if (req && avs_read) begin
      next_r.rd_pend = 1'b1;
    end else if (req && !full_byte) begin
      next_r.hi_nib = avs_writedata[7:4];
      next_r.lo_nibble = 1'b1;
      next_r.ack = 1'b1;
    end else if (req) begin
      next_r.ack = 1'b1;
      next_r.lo_nibble = 1'b0;
      next_r.st = cld_pkg::CLD_EXEC;
      next_r.busy_cnt = 20'(SHORT_CYCLES);
      if (avs_address == 1'b1) begin
        disp_we = !r.pat_sel;
        disp_wd = wbyte;
        pat_we = r.pat_sel;
        next_r.ac = cld_step(r.ac, r.md.entry_inc, r.md.two_line,
                             r.pat_sel);
        if (!r.pat_sel && r.md.entry_shift) begin
          next_r.offs = cld_shift(r.offs, r.md.entry_inc);
        end
      end else if (cmd[7]) begin
        next_r.ac = cmd[6:0];
        next_r.pat_sel = 1'b0;
      end else if (cmd[6]) begin
        next_r.ac = {1'b0, cmd[5:0]};
        next_r.pat_sel = 1'b1;
      end else if (cmd[5]) begin
        next_r.md.bus_width_sel = cmd[4];
        next_r.md.two_line = cmd[3];
        next_r.md.font_tall = cmd[2];
      end else if (cmd[4]) begin
        if (cmd[3]) begin
          next_r.offs = cld_shift(r.offs, !cmd[2]);
        end else begin
          next_r.ac = cld_step(r.ac, cmd[2], r.md.two_line, 1'b0);
        end
      end else if (cmd[3]) begin
        next_r.md.disp_on = cmd[2];
        next_r.md.cursor_on = cmd[1];
        next_r.md.blink_on = cmd[0];
      end else if (cmd[2]) begin
        next_r.md.entry_inc = cmd[1];
        next_r.md.entry_shift = cmd[0];
      end else if (cmd[1]) begin
        next_r.ac = cld_pkg::ADDR_ZERO;
        next_r.offs = '0;
        next_r.pat_sel = 1'b0;
        next_r.busy_cnt = 20'(LONG_CYCLES);
      end else if (cmd[0]) begin
        next_r.ac = cld_pkg::ADDR_ZERO;
        next_r.offs = '0;
        next_r.pat_sel = 1'b0;
        next_r.md.entry_inc = 1'b1;
        next_r.fill_addr = '0;
        next_r.st = cld_pkg::CLD_FILL;
        next_r.busy_cnt = 20'(LONG_CYCLES);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
      r.md.entry_inc <= 1'b1;
      r.md.bus_width_sel <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // waitrequest drops in the cycle the answer is presented
  assign avs_waitrequest = !r.ack;
  assign avs_readdata = r.rdata;
  assign mode = r.md;
  assign shift_offset = r.offs;
  assign addr_counter = r.ac;
  assign busy_flag = r.st != cld_pkg::CLD_IDLE;
  assign blink_phase = r.blink && r.md.blink_on;
endmodule
`default_nettype wire

/* File: dv/cld_decoder_checker.sv */
// concurrent checks on the decoder's bus, busy and mode ports
`timescale 1ns/1ps
`default_nettype none
module cld_decoder_checker #(
  parameter int unsigned LONG_CYCLES = cld_pkg::LONG_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // bus
  input wire logic [0:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  // panel state
  input wire cld_pkg::cld_mode_t mode,
  input wire logic [6:0] shift_offset,
  input wire logic [6:0] addr_counter,
  input wire logic busy_flag,
  input wire logic blink_phase
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [15:0] busy_len;
  wire [7:0] iw = avs_writedata[7:0];
  // length of the current busy stretch, sampled when it ends
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      busy_len <= '0;
    else
      busy_len <= busy_flag ? busy_len + 16'h0001 : '0;
  end
  // 4-bit mode acks a first nibble without executing, so 8-bit only
  sequence s_instr;
    avs_write && !avs_address[0] && !avs_waitrequest && mode.bus_width_sel;
  endsequence
  AST_BUSY_START: assert property ((avs_write && !avs_waitrequest && mode.bus_width_sel) |=> ##1 busy_flag)
    else $error("busy did not start after a write");
  AST_BUSY_LEN: assert property ($fell(busy_flag) |-> (busy_len == 16'(cld_pkg::SHORT_CYC) || busy_len == 16'(LONG_CYCLES)))
    else $error("busy stretch of wrong length");
  // busy rises with the ack, so only a still-waiting write is looked at
  AST_NO_TAKE_BUSY: assert property (busy_flag && avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("write taken while busy");
  AST_ENTRY: assert property (s_instr ##0 (iw[7:2] == 6'h01) |=> {mode.entry_inc, mode.entry_shift} == $past(iw[1:0]))
    else $error("entry mode not stored");
  AST_ONOFF: assert property (s_instr ##0 (iw[7:3] == 5'h01) |=> {mode.disp_on, mode.cursor_on, mode.blink_on} == $past(iw[2:0]))
    else $error("display control not stored");
  AST_FUNC: assert property (s_instr ##0 (iw[7:5] == 3'h1) |=> {mode.bus_width_sel, mode.two_line, mode.font_tall} == $past(iw[4:2]))
    else $error("function set not stored");
  AST_PAT_ADDR: assert property (s_instr ##0 (iw[7:6] == 2'h1) |=> addr_counter == {1'b0, $past(iw[5:0])})
    else $error("pattern address not loaded");
  AST_DISP_ADDR: assert property (s_instr ##0 iw[7] |=> addr_counter == $past(iw[6:0]))
    else $error("display address not loaded");
  AST_DSHIFT_AC: assert property (s_instr ##0 (iw[7:3] == 5'h03) |=> $stable(addr_counter)[*3])
    else $error("display shift moved the counter");
  AST_HOME: assert property (s_instr ##0 (iw[7:1] == 7'h01) |=> ##[0:2] (addr_counter == 7'h00 && shift_offset == 7'h00))
    else $error("home did not zero counter and offset");
  AST_BLINK_OFF: assert property (!mode.blink_on && !$past(mode.blink_on) |-> !blink_phase)
    else $error("blink phase active with blink off");
endmodule
bind cld_decoder cld_decoder_checker #(.LONG_CYCLES(LONG_CYCLES)) u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .mode(mode),
  .shift_offset(shift_offset), .addr_counter(addr_counter),
  .busy_flag(busy_flag), .blink_phase(blink_phase));
`default_nettype wire

/* File: dv/cld_host.sv */
// host processor model driving the decoder's bus
`timescale 1ns/1ps
`default_nettype none
module cld_host (
  // clock
  input wire logic sys_clk,
  // bus
  output logic [0:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end
  // request held until the rising edge that samples waitrequest low
  task automatic xfer(input logic rd, input logic a, input logic [7:0] d,
                      output logic [7:0] q, output bit ok);
    int n;
    ok = 1'b0;
    q = 8'h00;
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= {24'h0, d};
    for (n = 0; n < 2000 && !ok; n++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) begin
        ok = 1'b1;
        q = avs_readdata[7:0];
      end
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // 4-bit mode: status comes as two reads, busy in the first one
  task automatic ready(input bit nib, output bit ok);
    logic [7:0] s;
    logic [7:0] t;
    int n;
    ok = 1'b0;
    for (n = 0; n < 1000 && !ok; n++) begin
      xfer(1'b1, 1'b0, 8'h00, s, ok);
      if (ok && nib)
        xfer(1'b1, 1'b0, 8'h00, t, ok);
      ok = ok && (s[7] === 1'b0);
    end
  endtask
endmodule
`default_nettype wire

/* File: dv/cld_decoder_tb.sv */
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module cld_decoder_tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [0:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, busy_flag, blink_phase;
  logic [31:0] avs_writedata, avs_readdata;
  logic [6:0] shift_offset, addr_counter;
  cld_pkg::cld_mode_t mode;
  int fails = 0;
  int compares = 0;
  logic [7:0] q;
  bit nib4 = 1'b0;
  always #10 sys_clk = ~sys_clk;
  cld_decoder #(.LONG_CYCLES(300), .BLINK_CYCLES(50)) DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mode(mode),
    .shift_offset(shift_offset), .addr_counter(addr_counter),
    .busy_flag(busy_flag), .blink_phase(blink_phase));
  cld_host host (.sys_clk(sys_clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  task automatic chk(input string what, input logic [7:0] got, exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // every access waits for ready first; a: 0 instruction, 1 data
  task automatic acc(input logic rd, input logic a, input logic [7:0] d);
    bit ok;
    logic [7:0] hi;
    host.ready(nib4, ok);
    if (ok && nib4) begin
      host.xfer(rd, a, d, hi, ok);
      if (ok)
        host.xfer(rd, a, {d[3:0], 4'h0}, q, ok);
      q = {hi[7:4], q[7:4]};
    end else if (ok) begin
      host.xfer(rd, a, d, q, ok);
    end
    if (!ok) begin
      fails++;
      $display("[ERR] bus wait expected done seen timeout");
      wrap_up;
    end
  endtask
  initial begin
    bit ok;
    int n;
    repeat (8) @(posedge sys_clk);
    chk("mode reset", mode, 8'h84);
    reset_n <= 1'b1;
    acc(0, 0, 8'h01);
    host.xfer(1'b1, 1'b0, 8'h00, q, ok);
    chk("busy bit", {7'h00, q[7]}, 8'h01);
    // a write made while busy waits until the clear has ended
    host.xfer(1'b0, 1'b0, 8'h08, q, ok);
    chk("stall done", {7'h00, ok}, 8'h01);
    acc(1, 0, 8'h00);
    chk("ac clear", q, 8'h00);
    acc(0, 1, 8'h41);
    acc(0, 1, 8'h42);
    acc(1, 0, 8'h00);
    chk("ac inc", q, 8'h02);
    acc(0, 0, 8'h80);
    acc(1, 1, 8'h00);
    chk("rd 0", q, 8'h41);
    acc(1, 1, 8'h00);
    chk("rd 1", q, 8'h42);
    acc(1, 1, 8'h00);
    chk("rd space", q, 8'h20);
    acc(0, 0, 8'h04);
    acc(0, 0, 8'h85);
    acc(0, 1, 8'h55);
    acc(1, 0, 8'h00);
    chk("ac dec", q, 8'h04);
    acc(0, 0, 8'h48);
    acc(0, 1, 8'h1F);
    acc(1, 0, 8'h00);
    chk("pat ac", q, 8'h07);
    acc(0, 0, 8'h48);
    acc(1, 1, 8'h00);
    chk("pat rd", q, 8'h1F);
    $display("test ram done");
    acc(0, 0, 8'h06);
    acc(0, 0, 8'h90);
    acc(0, 0, 8'h14);
    acc(1, 0, 8'h00);
    chk("cur right", q, 8'h11);
    acc(0, 0, 8'h10);
    acc(1, 0, 8'h00);
    chk("cur left", q, 8'h10);
    acc(0, 0, 8'h18);
    acc(0, 0, 8'h18);
    acc(1, 0, 8'h00);
    chk("shift ac", q, 8'h10);
    chk("ofs left", {1'b0, shift_offset}, 8'h02);
    acc(0, 0, 8'h1C);
    acc(0, 0, 8'h07);
    acc(0, 1, 8'h33);
    acc(1, 0, 8'h00);
    chk("ofs write", {1'b0, shift_offset}, 8'h02);
    acc(0, 0, 8'h02);
    acc(1, 0, 8'h00);
    chk("home ac", q, 8'h00);
    chk("home ofs", {1'b0, shift_offset}, 8'h00);
    acc(1, 1, 8'h00);
    chk("home ram", q, 8'h41);
    $display("test shift done");
    acc(0, 0, 8'h38);
    acc(0, 0, 8'hA7);
    acc(0, 0, 8'h14);
    acc(1, 0, 8'h00);
    chk("line wrap", q, 8'h40);
    chk("mode two", mode, 8'hC6);
    acc(0, 0, 8'h34);
    acc(0, 0, 8'h0F);
    acc(1, 0, 8'h00);
    chk("mode on", mode, 8'hFD);
    for (n = 0; n < 300 && blink_phase !== 1'b1; n++)
      @(posedge sys_clk);
    chk("blink", {7'h00, blink_phase}, 8'h01);
    acc(0, 0, 8'h08);
    acc(1, 0, 8'h00);
    chk("mode off", mode, 8'hC5);
    chk("blink off", {7'h00, blink_phase}, 8'h00);
    $display("test mode done");
    acc(0, 0, 8'h20);
    nib4 = 1'b1;
    acc(0, 0, 8'h87);
    acc(0, 1, 8'hA5);
    acc(1, 0, 8'h00);
    chk("nib ac", q, 8'h08);
    chk("nib ofs", {1'b0, shift_offset}, 8'h01);
    acc(0, 0, 8'h87);
    acc(1, 1, 8'h00);
    chk("nib rd", q, 8'hA5);
    acc(0, 0, 8'h30);
    nib4 = 1'b0;
    chk("mode byte", mode, 8'hC4);
    $display("test nibble done");
    wrap_up;
  end
endmodule
`default_nettype wire
